// *** rtl/sau_consts.svh ***
// constants for the secure access unit register tail
`ifndef SAU_CONSTS_SVH
`define SAU_CONSTS_SVH
`define SAU_OFS_FLAG_CLEAR     8'h20
`define SAU_OFS_CHAN_INFO      8'h24
`define SAU_OFS_REVISION       8'h28
`define SAU_OFS_UNLOCK         8'hFC
`define SAU_OFS_STATUS         8'h10
`define SAU_OFS_MASK_SET       8'h14
`define SAU_OFS_MASK_CLR       8'h18
`define SAU_OFS_MASK_STATE     8'h1C
`define SAU_CHANNELS           16
`define SAU_REMAP_RESET        32'h00000000
`define SAU_BIT_EXP            0
`define SAU_BIT_CAS            1
`define SAU_BIT_CAU            2
`define SAU_BIT_UNLOCK_REG_READ         3
`define SAU_BIT_UNLOCK_KEY_ERROR          4
`define SAU_BIT_UNLOCK_WHILE_ERROR           5
`define SAU_BIT_MBERR          6
`define SAU_BIT_REMAP_ADDRESS_ERROR         7
`define SAU_ERR_MASK           8'hF4
`define SAU_KEY_LSB            8
`define SAU_KEY_MSB            15
`define SAU_CHAN_MSB           5
`define SAU_REMAP_HI_MIN       16'hFFFC
`define SAU_VERSION_DEFAULT    12'h123
`define SAU_VARIANT_DEFAULT    4'h0
`define SAU_UNLOCK_WIN_NS      2000
`define SAU_CLK_NS             25
`define SAU_UNLOCK_WIN_CYC     ((`SAU_UNLOCK_WIN_NS) / (`SAU_CLK_NS))
`endif

// *** rtl/sau_pkg.sv ***
// types for the secure access unit register tail
package sau_pkg;
  typedef enum logic [1:0]
  {
    SAU_IDLE   = 2'b00,
    SAU_OPEN   = 2'b01,
    SAU_ACCESS = 2'b10
  } sau_unlock_e;
  typedef logic [7:0] sau_flags_t;
endpackage

// *** rtl/sau_remap_bank.sv ***
// per-channel remap target registers
`timescale 1ns/100ps
`include "sau_consts.svh"
module sau_remap_bank
  import sau_pkg::*;
#(
  parameter int CHANNELS = `SAU_CHANNELS
)
(
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic                        ce,
  input  wire logic                        wr_en,
  input  wire logic [$clog2(CHANNELS)-1:0] wr_idx,
  input  wire logic [31:0]                 wr_data,
  input  wire logic [$clog2(CHANNELS)-1:0] rd_idx,
  output logic      [31:0]                 rd_data
);
  logic [31:0] remap_target_ff [CHANNELS];
  logic [31:0] nxt_remap_target [CHANNELS];

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_chan
      always_comb
      begin
        nxt_remap_target[g] = remap_target_ff[g];
        if (wr_en && (wr_idx == g[$clog2(CHANNELS)-1:0]))
          nxt_remap_target[g] = wr_data;
      end
      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
          remap_target_ff[g] <= `SAU_REMAP_RESET;
        else if (ce)
          remap_target_ff[g] <= nxt_remap_target[g];
      end
    end
  endgenerate

  assign rd_data = remap_target_ff[rd_idx];
endmodule

// *** rtl/secure_access_unit_regs.sv ***
// register tail of the secure access unit: flags, clear, info, remap, unlock
`timescale 1ns/100ps
`include "sau_consts.svh"
module secure_access_unit_regs
  import sau_pkg::*;
#(
  parameter int          CHANNELS = `SAU_CHANNELS,
  parameter logic [11:0] VERSION  = `SAU_VERSION_DEFAULT, // arbitrary value
  parameter logic [3:0]  VARIANT  = `SAU_VARIANT_DEFAULT, // arbitrary value
  parameter int          UNLOCK_WIN_CYC = `SAU_UNLOCK_WIN_CYC
)
(
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic                        ce,
  input  wire logic                        fast_bus_clock_en,
  input  wire logic                        periph_bus_clock_en,
  input  wire logic                        reg_sel,
  input  wire logic                        reg_wr,
  input  wire logic [7:0]                  reg_addr,
  input  wire logic [31:0]                 reg_wdata,
  output logic      [31:0]                 reg_rdata,
  input  wire logic [7:0]                  configured_unlock_key,
  input  wire logic [CHANNELS-1:0]         chan_enable,
  input  wire logic                        chan_access,
  input  wire logic [$clog2(CHANNELS)-1:0] chan_access_idx,
  input  wire logic                        master_bus_error,
  output logic                             chan_grant,
  output logic      [31:0]                 remap_addr,
  output logic                             irq
);
  localparam int CW = $clog2(CHANNELS);

  sau_flags_t     unit_status_ff, nxt_unit_status;
  sau_flags_t     irq_mask_state_ff, nxt_irq_mask_state;
  sau_unlock_e    state_ff, nxt_state;
  logic [CW-1:0]  open_chan_ff, nxt_open_chan;
  logic [15:0]    win_cnt_ff, nxt_win_cnt;
  logic [31:0]    reg_rdata_ff, nxt_reg_rdata;
  logic           chan_grant_ff, nxt_chan_grant;
  logic [31:0]    remap_addr_ff, nxt_remap_addr;
  logic           irq_ff, nxt_irq;
  logic [31:0]    remap_rd;
  logic [CW-1:0]  remap_rd_idx;

  // peripheral-side logic, fast-side flags and the SAU_OPEN window advance only while their gated clocks run
  logic pb_ce;
  logic hs_ce;
  assign pb_ce = ce & periph_bus_clock_en;
  assign hs_ce = ce & fast_bus_clock_en;

  logic bus_wr;
  logic bus_rd;
  logic ctrl_hit;
  logic remap_hit;
  logic unlock_wr;
  logic key_ok;
  logic [CW-1:0] unlock_chan;
  assign bus_wr      = reg_sel & reg_wr & pb_ce;
  assign bus_rd      = reg_sel & ~reg_wr & pb_ce;
  // named registers shadow remap 4 to 10: those targets stay at reset, reachable only through a grant
  assign ctrl_hit    = (reg_addr >= `SAU_OFS_STATUS) && (reg_addr <= `SAU_OFS_REVISION);
  assign remap_hit   = (reg_addr[7:2] < CHANNELS[5:0]) && (reg_addr[1:0] == 2'b00) && !ctrl_hit;
  assign unlock_wr   = bus_wr && (reg_addr == `SAU_OFS_UNLOCK);
  assign key_ok      = reg_wdata[`SAU_KEY_MSB:`SAU_KEY_LSB] == configured_unlock_key;
  assign unlock_chan = reg_wdata[CW-1:0];
  assign remap_rd_idx = bus_rd ? reg_addr[CW+1:2] : chan_access_idx;

  sau_remap_bank #(
    .CHANNELS (CHANNELS)
  ) u_remap (
    .clk     (clk),
    .rstn    (rstn),
    .ce      (pb_ce),
    .wr_en   (bus_wr && remap_hit),
    .wr_idx  (reg_addr[CW+1:2]),
    .wr_data (reg_wdata),
    .rd_idx  (remap_rd_idx),
    .rd_data (remap_rd)
  );

  // status flags: hardware sets win over a clear in the same cycle
  always_comb
  begin
    sau_flags_t set_v;
    sau_flags_t clr_v;
    set_v = '0;
    clr_v = '0;
    nxt_irq_mask_state = irq_mask_state_ff;
    if (bus_wr && reg_addr == `SAU_OFS_FLAG_CLEAR)
      clr_v = reg_wdata[7:0];
    if (bus_wr && reg_addr == `SAU_OFS_MASK_SET)
      nxt_irq_mask_state = irq_mask_state_ff | reg_wdata[7:0];
    if (bus_wr && reg_addr == `SAU_OFS_MASK_CLR)
      nxt_irq_mask_state = irq_mask_state_ff & ~reg_wdata[7:0];
    if (bus_rd && reg_addr == `SAU_OFS_UNLOCK)
      set_v[`SAU_BIT_UNLOCK_REG_READ] = 1'b1;
    if (unlock_wr && (unit_status_ff & `SAU_ERR_MASK) != 8'h00)
      set_v[`SAU_BIT_UNLOCK_WHILE_ERROR] = 1'b1;
    else if (unlock_wr && !key_ok)
      set_v[`SAU_BIT_UNLOCK_KEY_ERROR] = 1'b1;
    if (hs_ce && chan_access &&
        !(state_ff == SAU_OPEN && open_chan_ff == chan_access_idx && chan_enable[chan_access_idx]))
      set_v[`SAU_BIT_CAU] = 1'b1;
    if (hs_ce && chan_access && state_ff == SAU_OPEN && open_chan_ff == chan_access_idx &&
        chan_enable[chan_access_idx])
      set_v[`SAU_BIT_CAS] = 1'b1;
    if (hs_ce && state_ff == SAU_OPEN && win_cnt_ff == 16'h0001 && !chan_access)
      set_v[`SAU_BIT_EXP] = 1'b1;
    if (hs_ce && master_bus_error)
      set_v[`SAU_BIT_MBERR] = 1'b1;
    if (bus_wr && remap_hit && reg_wdata[31:16] < `SAU_REMAP_HI_MIN)
      set_v[`SAU_BIT_REMAP_ADDRESS_ERROR] = 1'b1;
    nxt_unit_status = (unit_status_ff & ~clr_v) | set_v;
  end

  // unlock window machine
  always_comb
  begin
    nxt_state      = state_ff;
    nxt_open_chan  = open_chan_ff;
    nxt_win_cnt    = win_cnt_ff;
    nxt_chan_grant = 1'b0;
    nxt_remap_addr = remap_addr_ff;
    case (state_ff)
      SAU_IDLE:
      begin
        nxt_win_cnt = 16'h0000;
      end
      SAU_OPEN:
      begin
        if (hs_ce && chan_access && open_chan_ff == chan_access_idx && chan_enable[chan_access_idx])
        begin
          nxt_chan_grant = 1'b1;
          nxt_remap_addr = remap_rd;
          nxt_state      = SAU_ACCESS;
        end
        else if (hs_ce && win_cnt_ff == 16'h0001)
          nxt_state = SAU_IDLE;
        else if (hs_ce)
          nxt_win_cnt = win_cnt_ff - 16'h0001;
      end
      SAU_ACCESS:
      begin
        nxt_state = SAU_IDLE;
      end
      default:
      begin
        nxt_state = SAU_IDLE;
      end
    endcase
    if (unlock_wr && key_ok && (unit_status_ff & `SAU_ERR_MASK) == 8'h00)
    begin
      nxt_state     = SAU_OPEN;
      nxt_open_chan = unlock_chan;
      nxt_win_cnt   = UNLOCK_WIN_CYC[15:0];
    end
  end

  // register read data and interrupt line
  always_comb
  begin
    nxt_reg_rdata = reg_rdata_ff;
    if (bus_rd)
    begin
      nxt_reg_rdata = 32'h00000000;
      if (remap_hit)
        nxt_reg_rdata = remap_rd;
      else
        case (reg_addr)
          `SAU_OFS_STATUS:     nxt_reg_rdata = {24'h000000, unit_status_ff};
          `SAU_OFS_MASK_STATE: nxt_reg_rdata = {24'h000000, irq_mask_state_ff};
          `SAU_OFS_CHAN_INFO:  nxt_reg_rdata = {26'h0000000, CHANNELS[5:0]};
          `SAU_OFS_REVISION:   nxt_reg_rdata = {12'h000, VARIANT, 4'h0, VERSION};
          default:             nxt_reg_rdata = 32'h00000000;
        endcase
    end
    nxt_irq = (nxt_unit_status & nxt_irq_mask_state) != 8'h00;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      unit_status_ff    <= 8'h00;
      irq_mask_state_ff <= 8'h00;
      state_ff          <= SAU_IDLE;
      open_chan_ff      <= '0;
      win_cnt_ff        <= 16'h0000;
      reg_rdata_ff      <= 32'h00000000;
      chan_grant_ff     <= 1'b0;
      remap_addr_ff     <= 32'h00000000;
      irq_ff            <= 1'b0;
    end
    else if (ce)
    begin
      unit_status_ff    <= nxt_unit_status;
      irq_mask_state_ff <= nxt_irq_mask_state;
      state_ff          <= nxt_state;
      open_chan_ff      <= nxt_open_chan;
      win_cnt_ff        <= nxt_win_cnt;
      reg_rdata_ff      <= nxt_reg_rdata;
      chan_grant_ff     <= nxt_chan_grant;
      remap_addr_ff     <= nxt_remap_addr;
      irq_ff            <= nxt_irq;
    end
  end

  assign reg_rdata  = reg_rdata_ff;
  assign chan_grant = chan_grant_ff;
  assign remap_addr = remap_addr_ff;
  assign irq        = irq_ff;

  a_clear_one_bit: assert property (@(posedge clk) disable iff (!rstn)
    (ce && periph_bus_clock_en && reg_sel && reg_wr && reg_addr == `SAU_OFS_FLAG_CLEAR && reg_wdata[`SAU_BIT_UNLOCK_KEY_ERROR]
     && !unlock_wr) |=> !unit_status_ff[`SAU_BIT_UNLOCK_KEY_ERROR])
    else $error("flag not cleared");
  a_clear_zero_keeps: assert property (@(posedge clk) disable iff (!rstn)
    (bus_wr && reg_addr == `SAU_OFS_FLAG_CLEAR && unit_status_ff[`SAU_BIT_REMAP_ADDRESS_ERROR] && !reg_wdata[`SAU_BIT_REMAP_ADDRESS_ERROR])
    |=> unit_status_ff[`SAU_BIT_REMAP_ADDRESS_ERROR])
    else $error("flag lost on zero write");
  a_chan_count_read: assert property (@(posedge clk) disable iff (!rstn)
    (bus_rd && reg_addr == `SAU_OFS_CHAN_INFO) |=> reg_rdata == 32'h00000010)
    else $error("wrong channel count");
  a_version_read: assert property (@(posedge clk) disable iff (!rstn)
    (bus_rd && reg_addr == `SAU_OFS_REVISION) |=> reg_rdata[11:0] == VERSION && reg_rdata[31:20] == 12'h000)
    else $error("wrong version");
  a_bad_key_flag: assert property (@(posedge clk) disable iff (!rstn)
    (unlock_wr && !key_ok) |=> unit_status_ff[`SAU_BIT_UNLOCK_KEY_ERROR] || unit_status_ff[`SAU_BIT_UNLOCK_WHILE_ERROR])
    else $error("key error not flagged");
  a_unlock_blocked: assert property (@(posedge clk) disable iff (!rstn)
    (unlock_wr && (unit_status_ff & `SAU_ERR_MASK) != 8'h00) |=> unit_status_ff[`SAU_BIT_UNLOCK_WHILE_ERROR] && state_ff != SAU_OPEN)
    else $error("unlock not aborted");
  a_good_key_opens: assert property (@(posedge clk) disable iff (!rstn)
    (unlock_wr && key_ok && (unit_status_ff & `SAU_ERR_MASK) == 8'h00) |=> state_ff == SAU_OPEN && open_chan_ff == $past(unlock_chan))
    else $error("unlock failed");
  a_locked_access: assert property (@(posedge clk) disable iff (!rstn)
    (hs_ce && chan_access && state_ff == SAU_IDLE) |=> unit_status_ff[`SAU_BIT_CAU])
    else $error("access unsuccessful not set");
  a_irq_follows: assert property (@(posedge clk) disable iff (!rstn)
    ce |=> irq == (($past(nxt_unit_status) & $past(nxt_irq_mask_state)) != 8'h00))
    else $error("irq mismatch");
  c_unlock_grant: cover property (@(posedge clk) disable iff (!rstn) state_ff == SAU_OPEN ##[1:20] chan_grant);
  c_expire:       cover property (@(posedge clk) disable iff (!rstn) $rose(unit_status_ff[`SAU_BIT_EXP]));
  c_irq:          cover property (@(posedge clk) disable iff (!rstn) $rose(irq));
endmodule

// *** verification/sau_fast_model.sv ***
// fast-bus side model: channel access attempts and bus error replies
`timescale 1ns/100ps
module sau_fast_model
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       req,
  input  wire logic [3:0] req_idx,
  input  wire logic       err_req,
  output logic            chan_access,
  output logic      [3:0] chan_access_idx,
  output logic            master_bus_error
);
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      chan_access      <= 1'b0;
      chan_access_idx  <= 4'h0;
      master_bus_error <= 1'b0;
    end
    else
    begin
      chan_access      <= req;
      // index is meaningless outside a request, so it toggles to catch stale use
      chan_access_idx  <= req ? req_idx : ~chan_access_idx;
      master_bus_error <= err_req;
    end
  end
endmodule

// *** verification/tb.sv ***
// self-checking bench for the secure access unit register tail
`timescale 1ns/100ps
`include "sau_consts.svh"
module tb;
  import sau_pkg::*;
  logic        clk, rstn, reg_sel, reg_wr, req, err_req, periph_en, chan_access, mb_err, chan_grant, irq, rd_d;
  logic [7:0]  reg_addr, key;
  logic [31:0] reg_wdata, reg_rdata, remap_addr, seed, r;
  logic [15:0] chan_enable;
  logic [3:0]  req_idx, acc_idx, c, d, e;
  logic [31:0] remap [16];
  logic [31:0] rd_q [$];
  logic [31:0] gr_q [$];
  int          n_errors, check_count, cyc;

  secure_access_unit_regs #(.CHANNELS(16), .UNLOCK_WIN_CYC(4)) DUT (.clk(clk), .rstn(rstn), .ce(1'b1),
    .fast_bus_clock_en(1'b1), .periph_bus_clock_en(periph_en), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .configured_unlock_key(key),
    .chan_enable(chan_enable), .chan_access(chan_access), .chan_access_idx(acc_idx),
    .master_bus_error(mb_err), .chan_grant(chan_grant), .remap_addr(remap_addr), .irq(irq));
  sau_fast_model u_fast (.clk(clk), .rstn(rstn), .req(req), .req_idx(req_idx), .err_req(err_req),
    .chan_access(chan_access), .chan_access_idx(acc_idx), .master_bus_error(mb_err));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task end_sim;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] dat);
    @(posedge clk);
    reg_sel   <= 1'b1;
    reg_wr    <= wr;
    reg_addr  <= a;
    reg_wdata <= dat;
    @(posedge clk);
    reg_sel   <= 1'b0;
    reg_wr    <= 1'b0;
    reg_wdata <= ~dat;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus(1'b0, a, 32'h00000000);
  endtask

  task acc(input logic [3:0] idx, input logic grant);
    if (grant)
      gr_q.push_back(remap[idx]);
    @(posedge clk);
    req     <= 1'b1;
    req_idx <= idx;
    @(posedge clk);
    req     <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task wirq(input logic v);
    int i;
    for (i = 0; i < 8 && irq !== v; i++)
      @(posedge clk);
    chk({31'h0, irq}, {31'h0, v}, "irq");
  endtask

  // a grant or a read answer takes the oldest note; an empty queue forces a miss
  always @(posedge clk)
  begin
    if (rd_d)
      chk(reg_rdata, rd_q.size() ? rd_q.pop_front() : ~reg_rdata, "read data");
    if (chan_grant === 1'b1)
      chk(remap_addr, gr_q.size() ? gr_q.pop_front() : ~remap_addr, "grant target");
    rd_d <= reg_sel && !reg_wr && periph_en && rstn;
    cyc++;
    if (cyc == 4000)
    begin
      n_errors++;
      end_sim;
    end
  end

  initial
  begin
    rstn = 1'b0; reg_sel = 1'b0; reg_wr = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h00000000;
    req = 1'b0; req_idx = 4'h0; err_req = 1'b0; periph_en = 1'b1;
    seed = 32'hfc5a;
    key = $random(seed);
    r = $random(seed);
    c = r[3:0];
    d = c + 4'h1;
    e = c + 4'h2;
    chan_enable = (r[31:16] | (16'h1 << c)) & ~(16'h1 << e);
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    // offsets 0x10 to 0x28 belong to the named registers, not to remap targets
    for (int n = 0; n < 16; n++)
      if (n < 4 || n > 10)
        rd(8'(n * 4), `SAU_REMAP_RESET);
    rd(`SAU_OFS_CHAN_INFO, 32'h00000010);
    rd(`SAU_OFS_REVISION, {12'h000, `SAU_VARIANT_DEFAULT, 4'h0, `SAU_VERSION_DEFAULT});
    rd(8'h40, 32'h00000000);
    for (int n = 0; n < 16; n++)
    begin
      r = $random(seed);
      remap[n] = (n < 4 || n > 10) ? {14'h3FFF, r[17:16], r[15:2], 2'b00} : `SAU_REMAP_RESET;
      if (n < 4 || n > 10)
      begin
        bus(1'b1, 8'(n * 4), remap[n]);
        rd(8'(n * 4), remap[n]);
      end
    end
    // a write with the register side gated must not land
    @(posedge clk);
    periph_en <= 1'b0;
    bus(1'b1, 8'h00, remap[0] ^ 32'h00000FF0);
    periph_en <= 1'b1;
    rd(8'h00, remap[0]);
    // low mask bits stay off so a success or an expiry is silent
    bus(1'b1, `SAU_OFS_MASK_SET, 32'hFFFC00FC);
    rd(`SAU_OFS_MASK_STATE, 32'h000000FC);
    bus(1'b1, `SAU_OFS_FLAG_CLEAR, 32'h000000FF);
    wirq(1'b0);
    bus(1'b1, `SAU_OFS_UNLOCK, {16'h0000, key, 4'h0, c});
    acc(c, 1'b1);
    chk({31'h0, irq}, 32'h00000000, "silent success");
    bus(1'b1, `SAU_OFS_UNLOCK, {16'h0000, key, 4'h0, c});
    acc(d, 1'b0);
    wirq(1'b1);
    bus(1'b1, `SAU_OFS_FLAG_CLEAR, 32'h000000FB);
    repeat (4) @(posedge clk);
    chk({31'h0, irq}, 32'h00000001, "zero bits keep flag");
    bus(1'b1, `SAU_OFS_FLAG_CLEAR, 32'h00000004);
    wirq(1'b0);
    bus(1'b1, `SAU_OFS_UNLOCK, {16'h0000, key, 4'h0, e});
    acc(e, 1'b0);
    wirq(1'b1);
    bus(1'b1, `SAU_OFS_FLAG_CLEAR, 32'h000000FF);
    wirq(1'b0);
    bus(1'b1, `SAU_OFS_UNLOCK, {16'h0000, key ^ 8'h01, 4'h0, c});
    acc(c, 1'b0);
    wirq(1'b1);
    bus(1'b1, `SAU_OFS_FLAG_CLEAR, 32'h000000FF);
    wirq(1'b0);
    @(posedge clk);
    err_req <= 1'b1;
    @(posedge clk);
    err_req <= 1'b0;
    wirq(1'b1);
    bus(1'b1, `SAU_OFS_UNLOCK, {16'h0000, key, 4'h0, c});
    acc(c, 1'b0);
    bus(1'b1, `SAU_OFS_FLAG_CLEAR, 32'h000000FF);
    wirq(1'b0);
    bus(1'b1, `SAU_OFS_UNLOCK, {16'h0000, key, 4'h0, c});
    repeat (12) @(posedge clk);
    acc(c, 1'b0);
    wirq(1'b1);
    repeat (4) @(posedge clk);
    chk(32'(gr_q.size()), 32'h00000000, "grants outstanding");
    chk(32'(rd_q.size()), 32'h00000000, "reads outstanding");
    end_sim;
  end
endmodule
